// file: hdl/rcsr_edge.sv
// Rising edge detector, one pulse per rising edge
`timescale 1ns/1ps
`default_nettype none
module rcsr_edge #(
  parameter int W = 1
) (
  input  wire logic         clk_i,    // Core clock
  input  wire logic         rst_n_i,  // Sync reset, active low
  input  wire logic [W-1:0] lvl_i,    // Synchronised level
  output logic      [W-1:0] rise_o    // One-cycle pulse on rise
);
  typedef struct packed {
    logic [W-1:0] last;
  } rcsr_edge_s;

  rcsr_edge_s st_reg;
  rcsr_edge_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.last = lvl_i;
  end

  // Reset to ones: a level already high at release is no new event
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise_o = lvl_i & ~st_reg.last;
endmodule
`default_nettype wire

// file: hdl/rcsr_params.svh
// Offsets, field positions and reset values of the reset cause block
`ifndef RCSR_PARAMS_SVH
`define RCSR_PARAMS_SVH

// Byte addresses on the register bus
`define RCSR_OFS_CAUSE     4'h0
`define RCSR_OFS_IRQ_STAT  4'h4
`define RCSR_OFS_IRQ_CLR   4'h8
`define RCSR_OFS_IRQ_EN    4'hc

// Bit positions inside the cause register
`define RCSR_BIT_TRAP      15
`define RCSR_BIT_OPCODE    14
`define RCSR_BIT_FLASHREG  11
`define RCSR_BIT_CFGMIS    9
`define RCSR_BIT_MAINREG   8
`define RCSR_BIT_PIN       7
`define RCSR_BIT_INSTR     6
`define RCSR_BIT_WDSOFT    5
`define RCSR_BIT_WDEXP     4
`define RCSR_BIT_SLEEP     3
`define RCSR_BIT_IDLE      2
`define RCSR_BIT_BROWN     1
`define RCSR_BIT_POWER     0

// Implemented bits and the power-on value
`define RCSR_IMPL_MASK     16'hcbff
`define RCSR_POR_VALUE     16'h0003
`define RCSR_NUM_EVT       8

`endif

// file: hdl/rcsr_pkg.sv
// Types shared by the reset cause block
`default_nettype none
package rcsr_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } rcsr_bus_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } rcsr_bus_rsp_s;

  // One pulse per reset source, same order as event bits
  typedef struct packed {
    logic trap;
    logic opcode;
    logic cfgmis;
    logic pin;
    logic instr;
    logic wd_expire;
    logic brown;
    logic power;
  } rcsr_evt_s;

  typedef enum logic [1:0] {
    RCSR_IDLE,
    RCSR_ANSWER
  } rcsr_bus_e;

endpackage
`default_nettype wire

// file: hdl/rcsr_sync.sv
// Two flip-flop synchroniser for pins
`timescale 1ns/1ps
`default_nettype none
module rcsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,    // Core clock
  input  wire logic         rst_n_i,  // Sync reset, active low
  input  wire logic [W-1:0] d_i,      // Asynchronous level
  output logic      [W-1:0] q_o       // Synchronised level
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } rcsr_sync_s;

  rcsr_sync_s st_reg;
  rcsr_sync_s st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = d_i;
    st_next.stab = st_reg.meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.stab;
endmodule
`default_nettype wire

// file: hdl/rcsr_top.sv
// Reset cause status and control register with Avalon-MM slave
//
// Functional notes
// RQ1: Bit 15 records a trap-conflict reset; clear when none happened.
// RQ2: Bit 11 one keeps flash regulator active in sleep, zero standby.
// RQ3: Bit 9 records a configuration-mismatch reset.
// RQ4: Bit 8 one keeps main regulator active in sleep, zero standby.
// RQ5: Bit 7 records a reset through the master clear pin.
// RQ6: Bit 6 records execution of the reset instruction.
// RQ7: Bit 5 is software watchdog enable: one on, zero off.
// RQ8: Bit 4 records a watchdog timer time-out.
// RQ9: Software may set or clear every flag; writing never starts reset.
// RQ10: Fuse at one keeps watchdog running, software enable ignored.
// RQ11: Power-on sets bits 1 and 0; others zero; bits 13,12,10 zero.
// RQ12: Flags survive non-power-on resets; change only by source or write.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "rcsr_params.svh"
module rcsr_top (
  input  wire logic        CORE_CLK_I,        // 125 MHz core clock
  input  wire logic        RST_N_I,           // Sync reset, active low
  input  wire logic        POR_N_I,           // Power-on reset, active low
  input  wire logic        AVS_READ_I,        // Avalon read
  input  wire logic        AVS_WRITE_I,       // Avalon write
  input  wire logic [3:0]  AVS_ADDRESS_I,     // Avalon byte address
  input  wire logic [31:0] AVS_WRITEDATA_I,   // Avalon write data
  input  wire logic [3:0]  AVS_BYTEENABLE_I,  // Avalon byte enables
  output logic      [31:0] AVS_READDATA_O,    // Avalon read data
  output logic             AVS_WAITREQUEST_O, // Avalon wait request
  input  wire logic        TRAP_CONFLICT_I,   // Trap conflict reset, pulse
  input  wire logic        ILLEGAL_OP_I,      // Illegal opcode reset, pulse
  input  wire logic        CFG_MISMATCH_I,    // Config mismatch, pulse
  input  wire logic        MASTER_CLEAR_PIN_N_I, // Pin, active low
  input  wire logic        RESET_INSTR_I,     // Reset instruction, pulse
  input  wire logic        WATCHDOG_EXPIRE_I, // Watchdog expiry, pulse
  input  wire logic        BROWNOUT_I,        // Brown-out detect, pulse
  input  wire logic        SLEEP_ENTER_I,     // Sleep entered, pulse
  input  wire logic        IDLE_ENTER_I,      // Idle entered, pulse
  input  wire logic        WATCHDOG_FUSE_ENABLE_I, // Fuse, 1 unprogrammed
  output logic             WATCHDOG_RUN_O,    // Watchdog timer enable
  output logic             FLASH_REG_KEEP_O,  // Flash regulator kept
  output logic             MAIN_REG_KEEP_O,   // Main regulator kept
  output logic             IRQ_O              // Level interrupt
);

  typedef struct packed {
    logic [15:0]                    cause;
    logic [`RCSR_NUM_EVT-1:0]       irq_stat;
    logic [`RCSR_NUM_EVT-1:0]       irq_en;
    logic                           fuse;
    rcsr_pkg::rcsr_bus_e            bus;
    rcsr_pkg::rcsr_bus_rsp_s        rsp;
    logic                           wd_run;
    logic                           flash_keep;
    logic                           main_keep;
    logic                           irq;
  } rcsr_top_s;

  rcsr_top_s st_reg;
  rcsr_top_s st_next;

  rcsr_pkg::rcsr_bus_req_s req;
  rcsr_pkg::rcsr_evt_s     evt;
  logic [1:0]              pin_sync;
  logic                    pin_rise;
  logic                    hit;
  logic                    wr_cause;
  logic                    wr_clr;
  logic                    wr_en;
  logic [15:0]             wmask;
  logic [15:0]             set_bits;

  // Pin and fuse come from outside the clock domain
  rcsr_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (POR_N_I),
    .d_i     ({~MASTER_CLEAR_PIN_N_I, WATCHDOG_FUSE_ENABLE_I}),
    .q_o     (pin_sync)
  );

  // Only the pin needs an edge; the fuse is used as a level
  rcsr_edge #(
    .W (1)
  ) u_edge (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (POR_N_I),
    .lvl_i   (pin_sync[1]),
    .rise_o  (pin_rise)
  );

  always_comb begin
    req.read      = AVS_READ_I;
    req.write     = AVS_WRITE_I;
    req.address   = AVS_ADDRESS_I;
    req.writedata = AVS_WRITEDATA_I;
    evt.trap      = TRAP_CONFLICT_I;
    evt.opcode    = ILLEGAL_OP_I;
    evt.cfgmis    = CFG_MISMATCH_I;
    evt.pin       = pin_rise;
    evt.instr     = RESET_INSTR_I;
    evt.wd_expire = WATCHDOG_EXPIRE_I;
    evt.brown     = BROWNOUT_I;
    evt.power     = 1'b0;
  end

  // Only the low two lanes carry the 16-bit register
  assign wmask = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};

  // Taken when idle; a write lands only at the answer edge
  assign hit      = st_reg.bus == rcsr_pkg::RCSR_ANSWER;
  assign wr_cause = hit && req.write && req.address == `RCSR_OFS_CAUSE;
  assign wr_clr   = hit && req.write && req.address == `RCSR_OFS_IRQ_CLR;
  assign wr_en    = hit && req.write && req.address == `RCSR_OFS_IRQ_EN;

  always_comb begin
    set_bits                  = '0;
    set_bits[`RCSR_BIT_TRAP]  = evt.trap;   // RQ1
    set_bits[`RCSR_BIT_OPCODE] = evt.opcode;
    set_bits[`RCSR_BIT_CFGMIS] = evt.cfgmis; // RQ3
    set_bits[`RCSR_BIT_PIN]   = evt.pin;    // RQ5
    set_bits[`RCSR_BIT_INSTR] = evt.instr;  // RQ6
    set_bits[`RCSR_BIT_WDEXP] = evt.wd_expire; // RQ8
    set_bits[`RCSR_BIT_SLEEP] = SLEEP_ENTER_I;
    set_bits[`RCSR_BIT_IDLE]  = IDLE_ENTER_I;
    set_bits[`RCSR_BIT_BROWN] = evt.brown;
  end

  always_comb begin
    st_next = st_reg;
    st_next.fuse = pin_sync[0];
    // Software write first, then hardware sets win over it
    if (wr_cause) begin
      st_next.cause = (st_reg.cause & ~wmask) |
                      (req.writedata[15:0] & wmask); // RQ9
    end
    st_next.cause = (st_next.cause | set_bits) & `RCSR_IMPL_MASK; // RQ12
    if (wr_en) begin
      st_next.irq_en = req.writedata[`RCSR_NUM_EVT-1:0];
    end
    if (wr_clr) begin
      st_next.irq_stat = st_reg.irq_stat &
                         ~req.writedata[`RCSR_NUM_EVT-1:0];
    end
    st_next.irq_stat = st_next.irq_stat | evt;
    // Fuse at one forces the watchdog on regardless of soft enable
    st_next.wd_run = st_next.fuse |
                     st_next.cause[`RCSR_BIT_WDSOFT]; // RQ7 RQ10
    st_next.flash_keep = st_next.cause[`RCSR_BIT_FLASHREG]; // RQ2
    st_next.main_keep  = st_next.cause[`RCSR_BIT_MAINREG];  // RQ4
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);
    st_next.rsp.waitrequest = 1'b1;
    st_next.rsp.readdata    = '0;
    case (st_reg.bus)
      rcsr_pkg::RCSR_IDLE: begin
        if (req.read || req.write) begin
          st_next.bus             = rcsr_pkg::RCSR_ANSWER;
          st_next.rsp.waitrequest = 1'b0;
          if (req.read) begin
            case (req.address)
              `RCSR_OFS_CAUSE:
                st_next.rsp.readdata = {16'h0000, st_reg.cause};
              `RCSR_OFS_IRQ_STAT:
                st_next.rsp.readdata = {24'h000000, st_reg.irq_stat};
              `RCSR_OFS_IRQ_EN:
                st_next.rsp.readdata = {24'h000000, st_reg.irq_en};
              default:
                st_next.rsp.readdata = '0;
            endcase
          end
        end
      end
      rcsr_pkg::RCSR_ANSWER: begin
        st_next.bus = rcsr_pkg::RCSR_IDLE;
      end
      default: begin
        st_next.bus = rcsr_pkg::RCSR_IDLE;
      end
    endcase
  end

  // Power-on loads the cause start value and waitrequest high, all else zero; ordinary reset keeps the cause flags
  always_ff @(posedge CORE_CLK_I) begin
    if (!POR_N_I) begin
      st_reg       <= '0;
      st_reg.cause <= `RCSR_POR_VALUE; // RQ11
      st_reg.rsp.waitrequest <= 1'b1;
    end else if (!RST_N_I) begin
      st_reg.bus             <= rcsr_pkg::RCSR_IDLE;
      st_reg.rsp             <= '0;
      st_reg.rsp.waitrequest <= 1'b1;
      st_reg.cause           <= st_next.cause; // RQ12
      st_reg.irq_stat        <= st_next.irq_stat;
      st_reg.fuse            <= st_next.fuse;
      st_reg.wd_run          <= st_next.wd_run;
      st_reg.flash_keep      <= st_next.flash_keep;
      st_reg.main_keep       <= st_next.main_keep;
      st_reg.irq             <= st_next.irq;
    end else begin
      st_reg <= st_next;
    end
  end

  assign AVS_READDATA_O    = st_reg.rsp.readdata;
  assign AVS_WAITREQUEST_O = st_reg.rsp.waitrequest;
  assign WATCHDOG_RUN_O    = st_reg.wd_run;
  assign FLASH_REG_KEEP_O  = st_reg.flash_keep;
  assign MAIN_REG_KEEP_O   = st_reg.main_keep;
  assign IRQ_O             = st_reg.irq;

endmodule
`default_nettype wire

// file: test/rcsr_monitor.sv
// Port-level checks for the reset cause register block
`timescale 1ns/1ps
`default_nettype none
module rcsr_monitor (
  input wire logic        CORE_CLK_I,             // Core clock
  input wire logic        RST_N_I,                // Reset
  input wire logic        POR_N_I,                // Power-on reset
  input wire logic        AVS_READ_I,             // Read strobe
  input wire logic        AVS_WRITE_I,            // Write strobe
  input wire logic [3:0]  AVS_ADDRESS_I,          // Address
  input wire logic [31:0] AVS_READDATA_O,         // Read data
  input wire logic        AVS_WAITREQUEST_O,      // Wait request
  input wire logic        WATCHDOG_FUSE_ENABLE_I, // Fuse level
  input wire logic        WATCHDOG_RUN_O,         // Watchdog run
  input wire logic        FLASH_REG_KEEP_O,       // Flash keep
  input wire logic        MAIN_REG_KEEP_O         // Main keep
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I || !POR_N_I);

  sequence s_req;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence s_cause_ans;
    AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h0;
  endsequence

  property p_answer; s_req |=> !AVS_WAITREQUEST_O; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_wait_pulse; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer too long");
  property p_rd_idle; AVS_WAITREQUEST_O |-> AVS_READDATA_O == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_flash; s_cause_ans |-> AVS_READDATA_O[11] == FLASH_REG_KEEP_O;
  endproperty
  a_flash: assert property (p_flash) else $error("flash keep wrong");
  property p_main; s_cause_ans |-> AVS_READDATA_O[8] == MAIN_REG_KEEP_O;
  endproperty
  a_main: assert property (p_main) else $error("main keep wrong");
  // Fuse passes two sync stages, so it must sit low a while first
  property p_soft;
    (!WATCHDOG_FUSE_ENABLE_I)[*4] ##0 s_cause_ans
      |-> WATCHDOG_RUN_O == AVS_READDATA_O[5];
  endproperty
  a_soft: assert property (p_soft) else $error("soft enable wrong");
  property p_fuse; WATCHDOG_FUSE_ENABLE_I[*5] |-> WATCHDOG_RUN_O; endproperty
  a_fuse: assert property (p_fuse) else $error("fuse not obeyed");
  property p_unimpl;
    s_cause_ans |-> AVS_READDATA_O[31:16] == 16'h0
      && AVS_READDATA_O[13:12] == 2'h0 && !AVS_READDATA_O[10];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unused bits set");
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the reset cause register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst_n, por_n, rd, wr, pin_n, fuse;
  logic        wreq, run, fk, mk, irq;
  logic [3:0]  adr, be;
  logic [7:0]  ev;
  logic [31:0] wd, rdata, q;
  int          err_count, compares;
  int          bits[8] = '{15, 14, 9, 6, 4, 1, 3, 2};

  rcsr_top u_dut (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .POR_N_I(por_n),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_ADDRESS_I(adr),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
    .TRAP_CONFLICT_I(ev[0]), .ILLEGAL_OP_I(ev[1]), .CFG_MISMATCH_I(ev[2]),
    .MASTER_CLEAR_PIN_N_I(pin_n), .RESET_INSTR_I(ev[3]),
    .WATCHDOG_EXPIRE_I(ev[4]), .BROWNOUT_I(ev[5]), .SLEEP_ENTER_I(ev[6]),
    .IDLE_ENTER_I(ev[7]), .WATCHDOG_FUSE_ENABLE_I(fuse),
    .WATCHDOG_RUN_O(run), .FLASH_REG_KEEP_O(fk), .MAIN_REG_KEEP_O(mk),
    .IRQ_O(irq)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_of_test();
    $display("Compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] e,
                     input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic t_soft();
    bus(1'b1, 4'h0, 32'hffff);
    repeat (3) @(posedge clk);
    rdc(4'h0, 32'hcbff, "cause ones");
    chk("flash keep", 32'h1, 32'(fk));
    chk("main keep", 32'h1, 32'(mk));
    chk("watchdog run", 32'h1, 32'(run));
    bus(1'b1, 4'h0, 32'h0);
    repeat (3) @(posedge clk);
    rdc(4'h0, 32'h0, "cause zero");
    chk("flash off", 32'h0, 32'(fk));
    chk("main off", 32'h0, 32'(mk));
    chk("watchdog off", 32'h0, 32'(run));
    fuse <= 1'b1;
    repeat (6) @(posedge clk);
    chk("fuse run", 32'h1, 32'(run));
    fuse <= 1'b0;
    bus(1'b1, 4'h2, 32'hffff);
    rdc(4'h2, 32'h0, "unmapped");
    be <= 4'h1;
    bus(1'b1, 4'h0, 32'hffff);
    be <= 4'hf;
    rdc(4'h0, 32'h00ff, "low lane only");
    repeat (4) @(posedge clk);
  endtask

  task automatic t_events();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 4'h0, 32'h0);
      @(posedge clk);
      ev <= 8'h01 << i;
      @(posedge clk);
      ev <= 8'h00;
      repeat (2) @(posedge clk);
      rdc(4'h0, 32'h1 << bits[i], "event flag");
    end
    bus(1'b1, 4'h0, 32'h0);
    pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    pin_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc(4'h0, 32'h80, "pin flag");
  endtask

  // Warm reset keeps flags, power-on restores the start value
  task automatic t_sticky();
    bus(1'b1, 4'h0, 32'h0250);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdc(4'h0, 32'h0250, "sticky");
    por_n <= 1'b0;
    repeat (3) @(posedge clk);
    por_n <= 1'b1;
    rdc(4'h0, 32'h0003, "power-on");
  endtask

  task automatic t_irq();
    bus(1'b1, 4'hc, 32'h4);
    ev <= 8'h10;
    @(posedge clk);
    ev <= 8'h00;
    repeat (3) @(posedge clk);
    chk("irq set", 32'h1, 32'(irq));
    rdc(4'h4, 32'h4, "irq status");
    bus(1'b1, 4'hc, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'h0, 32'(irq));
    bus(1'b1, 4'hc, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq unmasked", 32'h1, 32'(irq));
    bus(1'b1, 4'h8, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, 32'(irq));
    rdc(4'h4, 32'h0, "status clear");
  endtask

  initial begin
    {rst_n, por_n, rd, wr, fuse} = 5'h0;
    pin_n = 1'b1;
    adr = 4'h0;
    be = 4'hf;
    wd = 32'h0;
    ev = 8'h00;
    err_count = 0;
    compares = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    rdc(4'h0, 32'h0003, "reset value");
    t_soft();
    t_events();
    t_sticky();
    t_irq();
    end_of_test();
  end

  // Whole run is well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("[FAIL] run expected done seen hang");
    end_of_test();
  end
endmodule

bind rcsr_top rcsr_monitor u_mon (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .POR_N_I(POR_N_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READDATA_O(AVS_READDATA_O),
  .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .WATCHDOG_FUSE_ENABLE_I(WATCHDOG_FUSE_ENABLE_I),
  .WATCHDOG_RUN_O(WATCHDOG_RUN_O), .FLASH_REG_KEEP_O(FLASH_REG_KEEP_O),
  .MAIN_REG_KEEP_O(MAIN_REG_KEEP_O)
);
`default_nettype wire
